/* File: verilog/psc_pkg.sv */
// psc_pkg: constants and types shared by the supply control and status logic
// assumes a 25 MHz system clock and a two-wire link clocked from its own pin
package psc_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ      = 25;
    localparam int T_DEB_US     = 100;
    localparam int T_ON_MIN_US  = 5000;
    localparam int T_REG_MAX_US = 400000;
    localparam int T_PG_ON_US   = 100000;
    localparam int T_PG_LOW_US  = 100000;
    localparam int T_THERM_US   = 2000;
    localparam int T_BLINK_US   = 250000;
    localparam int DEB_CYC      = T_DEB_US * CLK_MHZ;
    localparam int ON_MIN_CYC   = T_ON_MIN_US * CLK_MHZ;
    localparam int REG_MAX_CYC  = T_REG_MAX_US * CLK_MHZ;
    localparam int PG_ON_CYC    = T_PG_ON_US * CLK_MHZ;
    localparam int PG_LOW_CYC   = T_PG_LOW_US * CLK_MHZ;
    localparam int THERM_CYC    = T_THERM_US * CLK_MHZ;
    localparam int BLINK_CYC    = T_BLINK_US * CLK_MHZ;
    localparam int TW           = 24;
    localparam int DW           = 12;
    localparam logic [DW-1:0] DEB_LAST = DW'(DEB_CYC - 1);

    // ************************************************************
    // link addresses and bit slots
    // ************************************************************
    localparam logic [7:0] FRU_BASE = 8'hA0;
    localparam logic [7:0] PM_BASE  = 8'hB0;
    localparam int         EE_DEPTH = 256;
    localparam logic [3:0] RX_LAST  = 4'h7;
    localparam logic [3:0] RX_ACK   = 4'h8;
    localparam logic [3:0] TX_LAST  = 4'h8;
    localparam logic [3:0] TX_MACK  = 4'h9;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic temp_warn;
        logic ac_lost;
        logic gen_fail;
        logic over_cur;
        logic over_volt;
        logic under_volt;
        logic fan_fail;
    } psc_event_t;

    typedef struct packed {
        logic       on_b;
        logic       strap1;
        logic       strap0;
        logic       load_hi;
        logic       vout_ok;
        psc_event_t ev;
        logic       scl;
        logic       sda;
    } psc_pin_t;

    typedef struct packed {
        logic [7:0] sr;
        logic [3:0] cnt;
        logic [7:0] data;
        logic       tgl;
    } psc_rx_t;

    typedef enum logic [2:0] {SQ_OFF, SQ_DLY, SQ_RAMP, SQ_PGW, SQ_ON, SQ_FLT} psc_seq_t;
    typedef enum logic [2:0] {BS_IDLE, BS_ADR, BS_PTR, BS_WR, BS_RD} psc_bus_t;

endpackage

/* File: verilog/psc_link_rx.sv */
// psc_link_rx: bit collector of the two-wire slave, clocked by the link clock
// assumes clr is a flop output of the system domain, high outside frames
`timescale 1ns/1ps
`default_nettype none

module psc_link_rx (
    input  wire logic       scl_clk,
    input  wire logic       clr,
    input  wire logic       sda_i,
    output logic [7:0]      rx_byte,
    output logic            rx_tgl
);
    import psc_pkg::*;

    psc_rx_t st_q;
    psc_rx_t st_d;

    // the link clock stands still between frames, so the count is cleared
    // asynchronously by the frame logic instead of by a clock edge
    always_comb begin
        st_d = st_q;
        if (st_q.cnt == RX_ACK) begin
            st_d.cnt = '0;
        end else begin
            st_d.sr  = {st_q.sr[6:0], sda_i};
            st_d.cnt = st_q.cnt + 4'h1;
        end
        if (st_q.cnt == RX_LAST) begin
            st_d.data = {st_q.sr[6:0], sda_i};
            st_d.tgl  = ~st_q.tgl;
        end
    end

    always_ff @(posedge scl_clk or posedge clr) begin
        if (clr) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rx_byte = st_q.data;
    assign rx_tgl  = st_q.tgl;

endmodule // psc_link_rx

`default_nettype wire

/* File: verilog/psc_ctrl.sv */
// psc_ctrl: supply control and status logic - alert, straps, two-wire slave,
// power-on request sequencing and power-good timing
// assumes pins arrive unsynchronised and the link clock is the bus clock pin
//
// Notes on behaviour
// - temperature warning on any monitored part drives the alert low
// - load reduced within 2 ms of a thermal alert keeps the supply running
// - loss of input power drives the alert low in under 4 ms
// - each strap reads 0 when low and 1 when high, floating high
// - eeprom answers at A0h for straps 0/0 and A2h for 0/1
// - management target answers at B0h for 0/0 and B2h for 0/1
// - the device is a bus slave only; master clocks at most 100 kHz
// - system reads and writes eeprom contents over the two-wire bus
// - critical or warning events drive the alert low; high while all is OK
// - whenever alert is low the amber led is solid or blinking
// - main output on while request held low; off when high or open
// - main outputs off within 5 ms of request release
// - main outputs regulate no sooner than 5 ms, no later than 400 ms
// - power-good low within 5 ms of request release
// - power-good rises 100 to 500 ms after outputs regulate
// - power-good stays low at least 100 ms over an off/on cycle
`timescale 1ns/1ps
`default_nettype none

module psc_ctrl #(
    parameter logic [psc_pkg::TW-1:0] P_ON_MIN  = psc_pkg::TW'(psc_pkg::ON_MIN_CYC),
    parameter logic [psc_pkg::TW-1:0] P_REG_MAX = psc_pkg::TW'(psc_pkg::REG_MAX_CYC),
    parameter logic [psc_pkg::TW-1:0] P_PG_ON   = psc_pkg::TW'(psc_pkg::PG_ON_CYC),
    parameter logic [psc_pkg::TW-1:0] P_PG_LOW  = psc_pkg::TW'(psc_pkg::PG_LOW_CYC),
    parameter logic [psc_pkg::TW-1:0] P_THERM   = psc_pkg::TW'(psc_pkg::THERM_CYC),
    parameter logic [psc_pkg::TW-1:0] P_BLINK   = psc_pkg::TW'(psc_pkg::BLINK_CYC)
) (
    input  wire logic                SYS_CLK,
    input  wire logic                RST_B,
    input  wire logic                SCL_CLK,
    input  wire logic                SDA_I,
    output logic                     SDA_O,
    output logic                     SDA_OE,
    input  wire logic                REMOTE_ON_INPUT_B,
    input  wire logic                ADDR_STRAP_BIT0,
    input  wire logic                ADDR_STRAP_BIT1,
    input  wire psc_pkg::psc_event_t EVENTS,
    input  wire logic                LOAD_OVER_RATING,
    input  wire logic                VOUT_IN_REG,
    output logic                     MAIN_EN,
    output logic                     PWR_GOOD,
    output logic                     ALERT_O,
    output logic                     ALERT_OE,
    output logic                     LED_AMBER,
    output logic                     LED_GREEN
);
    import psc_pkg::*;

    typedef struct packed {
        psc_pin_t                     s1;
        psc_pin_t                     s2;
        logic                         scl_p;
        logic                         sda_p;
        logic [2:0]                   deb;
        logic [2:0][DW-1:0]           dcnt;
        psc_seq_t                     sq;
        logic [TW-1:0]                tmr;
        logic [TW-1:0]                pglo;
        logic [TW-1:0]                thc;
        logic [TW-1:0]                blk_c;
        logic                         blk;
        logic                         main;
        logic                         pg;
        logic                         alert;
        logic                         amber;
        logic                         green;
        psc_bus_t                     bs;
        logic                         clr;
        logic [1:0]                   tg_s;
        logic                         tg_seen;
        logic                         pm;
        logic [7:0]                   ptr;
        logic [7:0]                   tx;
        logic [3:0]                   txc;
        logic                         ack_pend;
        logic                         ack_on;
        logic                         more;
        logic                         oe;
        logic [EE_DEPTH-1:0][7:0]     mem;
    } psc_ctrl_t;

    psc_ctrl_t  st_q;
    psc_ctrl_t  st_d;
    psc_pin_t   pins;
    logic [7:0] rx_byte;
    logic       rx_tgl;
    logic       on_req;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       byte_ev;
    logic       hit_fru;
    logic       hit_pm;
    logic       tl;
    logic       crit;
    logic       trip;
    logic [7:0] rd;

    function automatic logic adr_hit(input logic [7:0] base,
                                     input logic [7:0] rx,
                                     input logic [1:0] strap);
        adr_hit = (rx[7:1] == (base[7:1] | {5'h00, strap}));
    endfunction

    // ************************************************************
    // link bit collector
    // ************************************************************
    psc_link_rx u_rx (
        .scl_clk (SCL_CLK),
        .clr     (st_q.clr),
        .sda_i   (SDA_I),
        .rx_byte (rx_byte),
        .rx_tgl  (rx_tgl)
    );

    assign pins = '{on_b: REMOTE_ON_INPUT_B, strap1: ADDR_STRAP_BIT1,
                    strap0: ADDR_STRAP_BIT0, load_hi: LOAD_OVER_RATING,
                    vout_ok: VOUT_IN_REG, ev: EVENTS, scl: SCL_CLK, sda: SDA_I};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [2:0] raw;
        raw  = 3'h0;
        st_d = st_q;
        // pins pass two flops before any system-clock logic reads them
        st_d.s1    = pins;
        st_d.s2    = st_q.s1;
        st_d.scl_p = st_q.s2.scl;
        st_d.sda_p = st_q.s2.sda;

        // debounce: request stored active high so reset means off
        raw = {~st_q.s2.on_b, st_q.s2.strap1, st_q.s2.strap0};
        for (int i = 0; i < 3; i++) begin
            if (raw[i] == st_q.deb[i]) begin
                st_d.dcnt[i] = '0;
            end else if (st_q.dcnt[i] == DEB_LAST) begin
                st_d.deb[i]  = raw[i];
                st_d.dcnt[i] = '0;
            end else begin
                st_d.dcnt[i] = st_q.dcnt[i] + 12'h001;
            end
        end
        on_req = st_q.deb[2];

        // alert and led
        crit = st_q.s2.ev.gen_fail | st_q.s2.ev.over_cur | st_q.s2.ev.over_volt
             | st_q.s2.ev.under_volt | st_q.s2.ev.fan_fail;
        st_d.alert = |st_q.s2.ev;
        if (st_q.blk_c >= P_BLINK - 24'h00_0001) begin
            st_d.blk_c = '0;
            st_d.blk   = ~st_q.blk;
        end else begin
            st_d.blk_c = st_q.blk_c + 24'h00_0001;
        end
        // critical events light amber solid, warnings blink it
        st_d.amber = st_d.alert & (crit | st_q.blk);

        // thermal: shut down only if load stays high for the whole window
        tl = st_q.s2.ev.temp_warn & st_q.s2.load_hi;
        if (!tl) begin
            st_d.thc = '0;
        end else if (st_q.thc != P_THERM - 24'h00_0001) begin
            st_d.thc = st_q.thc + 24'h00_0001;
        end
        trip = (tl && st_q.thc == P_THERM - 24'h00_0001)
             | st_q.s2.ev.over_cur | st_q.s2.ev.over_volt | st_q.s2.ev.gen_fail;

        // sequencer
        st_d.tmr = st_q.tmr + 24'h00_0001;
        case (st_q.sq)
            SQ_OFF: begin
                st_d.tmr = '0;
                if (on_req && !st_q.s2.ev.ac_lost) begin
                    st_d.sq = SQ_DLY;
                end
            end
            SQ_DLY: begin
                if (st_q.tmr == P_ON_MIN - 24'h00_0001) begin
                    st_d.sq = SQ_RAMP;
                end
            end
            SQ_RAMP: begin
                if (st_q.s2.vout_ok) begin
                    st_d.sq  = SQ_PGW;
                    st_d.tmr = '0;
                end else if (st_q.tmr >= P_REG_MAX - 24'h00_0001) begin
                    st_d.sq = SQ_FLT;
                end
            end
            SQ_PGW: begin
                if (!st_q.s2.vout_ok) begin
                    st_d.sq = SQ_FLT;
                end else if (st_q.tmr >= P_PG_ON - 24'h00_0001
                             && st_q.pglo >= P_PG_LOW) begin
                    st_d.sq = SQ_ON;
                end
            end
            SQ_ON: begin
                if (!st_q.s2.vout_ok) begin
                    st_d.sq = SQ_FLT;
                end
            end
            SQ_FLT: begin
                // a latched trip clears only by cycling the request
                st_d.tmr = '0;
                if (!on_req) begin
                    st_d.sq = SQ_OFF;
                end
            end
            default: begin
                st_d.sq = SQ_OFF;
            end
        endcase
        if (st_q.sq == SQ_DLY || st_q.sq == SQ_RAMP || st_q.sq == SQ_PGW
            || st_q.sq == SQ_ON) begin
            if (!on_req || st_q.s2.ev.ac_lost) begin
                st_d.sq  = SQ_OFF;
                st_d.tmr = '0;
            end else if (trip) begin
                st_d.sq = SQ_FLT;
            end
        end
        st_d.main  = (st_d.sq == SQ_RAMP) || (st_d.sq == SQ_PGW) || (st_d.sq == SQ_ON);
        st_d.pg    = (st_d.sq == SQ_ON);
        st_d.green = st_d.pg & ~st_d.alert;
        if (st_d.pg) begin
            st_d.pglo = '0;
        end else if (st_q.pglo < P_PG_LOW) begin
            st_d.pglo = st_q.pglo + 24'h00_0001;
        end

        // ************************************************************
        // two-wire slave, transmit and framing side
        // ************************************************************
        scl_rise = st_q.s2.scl & ~st_q.scl_p;
        scl_fall = ~st_q.s2.scl & st_q.scl_p;
        start    = st_q.s2.scl & st_q.scl_p & st_q.sda_p & ~st_q.s2.sda;
        stop     = st_q.s2.scl & st_q.scl_p & ~st_q.sda_p & st_q.s2.sda;
        byte_ev  = st_q.tg_s[1] ^ st_q.tg_seen;
        hit_fru  = adr_hit(FRU_BASE, rx_byte, st_q.deb[1:0]);
        hit_pm   = adr_hit(PM_BASE, rx_byte, st_q.deb[1:0]);
        rd       = st_q.pm ? {st_q.pg, st_q.s2.ev} : st_q.mem[st_q.ptr];

        st_d.tg_s    = {st_q.tg_s[0], rx_tgl};
        st_d.tg_seen = st_q.tg_s[1];
        if (stop) begin
            st_d.bs       = BS_IDLE;
            st_d.oe       = 1'b0;
            st_d.ack_pend = 1'b0;
            st_d.ack_on   = 1'b0;
            st_d.txc      = '0;
        end else if (start) begin
            st_d.bs       = BS_ADR;
            st_d.oe       = 1'b0;
            st_d.ack_pend = 1'b0;
            st_d.ack_on   = 1'b0;
            st_d.txc      = '0;
        end else begin
            if (byte_ev) begin
                case (st_q.bs)
                    BS_ADR: begin
                        if (hit_fru || hit_pm) begin
                            st_d.ack_pend = 1'b1;
                            st_d.pm       = hit_pm;
                            st_d.bs       = rx_byte[0] ? BS_RD : BS_PTR;
                        end else begin
                            st_d.bs = BS_IDLE;
                        end
                    end
                    BS_PTR: begin
                        st_d.ptr      = rx_byte;
                        st_d.ack_pend = 1'b1;
                        st_d.bs       = BS_WR;
                    end
                    BS_WR: begin
                        if (!st_q.pm) begin
                            st_d.mem[st_q.ptr] = rx_byte;
                        end
                        st_d.ptr      = st_q.ptr + 8'h01;
                        st_d.ack_pend = 1'b1;
                    end
                    default: begin
                        st_d.bs = st_q.bs;
                    end
                endcase
            end
            // the slave only ever pulls data low; the clock is never driven
            if (scl_fall) begin
                if (st_q.ack_pend) begin
                    st_d.oe       = 1'b1;
                    st_d.ack_pend = 1'b0;
                    st_d.ack_on   = 1'b1;
                end else if (st_q.ack_on || (st_q.bs == BS_RD
                             && st_q.txc == TX_MACK && st_q.more)) begin
                    st_d.ack_on = 1'b0;
                    st_d.oe     = 1'b0;
                    st_d.more   = 1'b0;
                    if (st_q.bs == BS_RD) begin
                        st_d.tx  = rd;
                        st_d.ptr = st_q.ptr + 8'h01;
                        st_d.oe  = ~rd[7];
                        st_d.txc = 4'h1;
                    end
                end else if (st_q.bs == BS_RD && st_q.txc != 4'h0
                             && st_q.txc < TX_LAST) begin
                    st_d.oe  = ~st_q.tx[3'(4'h7 - st_q.txc)];
                    st_d.txc = st_q.txc + 4'h1;
                end else if (st_q.bs == BS_RD && st_q.txc == TX_LAST) begin
                    st_d.oe  = 1'b0;
                    st_d.txc = TX_MACK;
                end
            end
            if (scl_rise && st_q.bs == BS_RD && st_q.txc == TX_MACK) begin
                if (st_q.s2.sda) begin
                    st_d.bs = BS_IDLE;
                end else begin
                    st_d.more = 1'b1;
                end
            end
        end
        // hold the bit collector cleared between frames, pulse it on start
        st_d.clr = start | (st_d.bs == BS_IDLE);
        if (st_q.clr) begin
            st_d.tg_s    = 2'h0;
            st_d.tg_seen = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign SDA_O     = 1'b0;
    assign SDA_OE    = st_q.oe;
    assign MAIN_EN   = st_q.main;
    assign PWR_GOOD  = st_q.pg;
    assign ALERT_O   = 1'b0;
    assign ALERT_OE  = st_q.alert;
    assign LED_AMBER = st_q.amber;
    assign LED_GREEN = st_q.green;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    property p_temp_alert;
        st_q.s2.ev.temp_warn |=> ALERT_OE;
    endproperty
    a_temp_alert: assert property (p_temp_alert) else $error("no alert on temp");

    property p_therm_hold;
        !(st_q.s2.ev.temp_warn && st_q.s2.load_hi) |=> st_q.thc == '0;
    endproperty
    a_therm_hold: assert property (p_therm_hold) else $error("thermal count kept");

    property p_therm_trip;
        (MAIN_EN && st_q.s2.ev.temp_warn && st_q.s2.load_hi
         && st_q.thc == P_THERM - 24'h00_0001) |=> !MAIN_EN;
    endproperty
    a_therm_trip: assert property (p_therm_trip) else $error("no thermal stop");

    property p_ac_alert;
        st_q.s2.ev.ac_lost |=> ALERT_OE;
    endproperty
    a_ac_alert: assert property (p_ac_alert) else $error("no alert on ac loss");

    property p_quiet;
        (st_q.s2.ev == '0) |=> !ALERT_OE;
    endproperty
    a_quiet: assert property (p_quiet) else $error("alert with no event");

    property p_led;
        ALERT_OE |-> (LED_AMBER || !$past(st_q.blk));
    endproperty
    a_led: assert property (p_led) else $error("amber off during alert");

    property p_led_off;
        !ALERT_OE |-> !LED_AMBER;
    endproperty
    a_led_off: assert property (p_led_off) else $error("amber without alert");

    property p_adr;
        (st_q.bs == BS_ADR && byte_ev && !start && !stop && (hit_fru || hit_pm))
            |=> st_q.ack_pend;
    endproperty
    a_adr: assert property (p_adr) else $error("own address not acked");

    property p_ee_wr;
        (st_q.bs == BS_WR && byte_ev && !st_q.pm && !start && !stop)
            |=> st_q.mem[$past(st_q.ptr)] == $past(rx_byte);
    endproperty
    a_ee_wr: assert property (p_ee_wr) else $error("eeprom write lost");

    property p_main_off;
        (!st_q.deb[2] && MAIN_EN) |=> !MAIN_EN;
    endproperty
    a_main_off: assert property (p_main_off) else $error("main stays on");

    property p_pg_off;
        !st_q.deb[2] |=> !PWR_GOOD;
    endproperty
    a_pg_off: assert property (p_pg_off) else $error("power good stays");

    property p_on_min;
        $rose(MAIN_EN) |-> ($past(st_q.sq) == SQ_DLY
                            && $past(st_q.tmr) == P_ON_MIN - 24'h00_0001);
    endproperty
    a_on_min: assert property (p_on_min) else $error("main enabled early");

    property p_reg_max;
        (st_q.sq == SQ_RAMP) |-> st_q.tmr < P_REG_MAX;
    endproperty
    a_reg_max: assert property (p_reg_max) else $error("ramp overran");

    property p_pg_on;
        $rose(PWR_GOOD) |-> ($past(st_q.tmr) >= P_PG_ON - 24'h00_0001
                             && $past(st_q.pglo) >= P_PG_LOW);
    endproperty
    a_pg_on: assert property (p_pg_on) else $error("power good early");

    c_pg_up: cover property ($rose(PWR_GOOD));
    c_fault: cover property (st_q.sq == SQ_FLT);
    c_rd:    cover property (st_q.bs == BS_RD && st_q.txc == TX_MACK && scl_rise);
    c_wr:    cover property (st_q.bs == BS_WR && byte_ev);

endmodule // psc_ctrl

`default_nettype wire

/* File: bench/psc_master.sv */
// psc_master: two-wire bus master in place of the management controller
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module psc_master #(parameter int H = 5000) (
    output logic      SCL,
    output logic      OE,
    input  wire logic SDA
);
    logic gap = 1'b0;
    initial begin
        SCL = 1'b1;
        OE  = 1'b0;
    end
    // ************************************************************
    // bus cycles, bit period 2*H ns
    // ************************************************************
    task automatic start;
        if (gap) #1000000;
        gap = 1'b0;
        OE  = 1'b0;
        #(H/2) SCL = 1'b1;
        #(H/2) OE = 1'b1;
        #(H/2) SCL = 1'b0;
        #(H/2);
    endtask
    task automatic bt(input logic b, output logic r);
        OE = !b;
        #(H/2) SCL = 1'b1;
        #H r = SDA;
        SCL = 1'b0;
        #(H/2);
    endtask
    task automatic wr(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bt(d[i], r);
        bt(1'b1, a);
    endtask
    task automatic rd(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
        bt(nack, r);
    endtask
    task automatic stop;
        OE = 1'b1;
        #(H/2) SCL = 1'b1;
        #(H/2) OE = 1'b0;
        #(H/2) gap = 1'b1;
    endtask
endmodule // psc_master
`default_nettype wire

/* File: bench/test_psc_ctrl.sv */
// test_psc_ctrl: self-checking bench of the supply control logic
// assumes psc_master drives the link clock and data line
`timescale 1ns/1ps
`default_nettype none
module test_psc_ctrl;
import psc_pkg::*;
logic sys_clk = 0, rst_b = 0, on_b = 1, ld = 0, vreg = 0, scl, m_oe, sda, ak;
logic sda_o, sda_oe, main_en, pg, al_o, al_oe, amb, grn;
logic strap0 = 1'b0, strap1 = 1'b0;
psc_event_t ev = '0;
int error_cnt = 0, checks_done = 0, cyc = 0, n;
logic [7:0] rd;
assign sda = !(m_oe | sda_oe);
always #20 sys_clk = !sys_clk;
psc_master m (.SCL(scl), .OE(m_oe), .SDA(sda));
psc_ctrl #(.P_ON_MIN(24'h32), .P_PG_ON(24'h64), .P_PG_LOW(24'h64),
    .P_THERM(24'h32), .P_BLINK(24'h14)) uut (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .SCL_CLK(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .REMOTE_ON_INPUT_B(on_b),
    .ADDR_STRAP_BIT0(strap0), .ADDR_STRAP_BIT1(strap1), .EVENTS(ev), .LOAD_OVER_RATING(ld),
    .VOUT_IN_REG(vreg), .MAIN_EN(main_en), .PWR_GOOD(pg), .ALERT_O(al_o),
    .ALERT_OE(al_oe), .LED_AMBER(amb), .LED_GREEN(grn));
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
        error_cnt++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic til(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 5000) begin
        @(posedge sys_clk);
        #1;
        c++;
    end
endtask
task automatic finish_test;
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
// a hung handshake ends the run as a failure
always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 99000) begin
        error_cnt++;
        finish_test();
    end
end
initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk); #1;
    chk({sda_o, al_o, main_en, pg, al_oe, amb, grn, sda_oe}, 8'h00);
    for (int i = 0; i < 7; i++) begin
        @(posedge sys_clk) ev <= psc_event_t'(7'h01 << i);
        repeat (5) @(posedge sys_clk); #1;
        chk(8'(al_oe), 8'h01);
        if (i < 5) chk(8'(amb), 8'h01);
        @(posedge sys_clk) ev <= '0;
    end
    repeat (5) @(posedge sys_clk) on_b <= 1'b0;
    til(main_en, 1'b1, n);
    // the wait starts four edges after the pin fell
    chk(8'(n + 4 >= 2550 && n + 4 <= 2560), 8'h01);
    ev.temp_warn <= 1'b1;
    ld <= 1'b1;
    repeat (40) @(posedge sys_clk) ld <= 1'b0;
    repeat (20) @(posedge sys_clk) ev <= '0; #1;
    chk(8'(main_en), 8'h01);
    @(posedge sys_clk) vreg <= 1'b1;
    til(pg, 1'b1, n);
    chk(8'(n >= 100 && n <= 106), 8'h01);
    @(posedge sys_clk) on_b <= 1'b1;
    til(pg, 1'b0, n);
    chk(8'(n <= 2510 && main_en === 1'b0), 8'h01);
    m.start(); m.wr(8'hA0, ak); chk(8'(ak), 8'h00);
    m.wr(8'h05, ak); m.wr(8'h3C, ak); m.stop(); chk(8'(ak), 8'h00);
    m.start(); m.wr(8'hA0, ak); m.wr(8'h05, ak);
    m.start(); m.wr(8'hA1, ak); m.rd(1'b1, rd); m.stop();
    chk(rd, 8'h3C);
    m.start(); m.wr(8'hB0, ak); m.stop(); chk(8'(ak), 8'h00);
    finish_test();
end
endmodule // test_psc_ctrl
`default_nettype wire
